/* design/pwm_channel.sv */
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
// Function
// - duty beyond period never matches, so pin stays at present level
// - sleep stops the counter and prescaler and holds the pin and output enable
// - during sleep the pin keeps its driven level
// - after wake the counter continues from its held value
// - output timing derives only from the system clock
// - reset makes pins inputs and restores config defaults, duty byte kept until power-on reset
// - prescaler divides by 1, 4 or 16
// - unimplemented control bits read zero, writes ignored
// - duty registers keep contents over all but power-on reset
// - step after count equals period clears count, sets pin unless duty is zero, latches duty
// - period is (period value+1) times 4 times prescale clocks
// - pin clears when 10-bit time base equals shadow duty
// - duty high byte and low bits latch only at period boundary
module pwm_channel #(
	parameter int DIR_BIT = 0
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        por_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	input  wire logic        sleep,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             modulated_output_pin,
	output logic             modulated_output_oe,
	output logic             irq
);
	import pwm_pkg::*;

	initial begin
		if (DIR_BIT < 0 || DIR_BIT > 7) begin
			$error("DIR_BIT must select a bit of the direction register");
		end
	end

	// ****************************************
	// registers
	// ****************************************
	logic [7:0] period_compare_value;
	logic [6:0] timebase_control;
	logic [5:0] channel_control;
	logic [7:0] duty_high_bits;
	logic [7:0] duty_shadow;
	logic [1:0] duty_shadow_low;
	logic [7:0] pin_direction;
	logic [1:0] alternate_pin_control;
	logic [0:0] irq_status;
	logic [0:0] irq_mask;

	timebase_if tb ();

	pwm_timebase u_timebase (
		.pclk    (pclk),
		.presetn (presetn),
		.tb      (tb.counter)
	);

	// ****************************************
	// bus decode
	// ****************************************
	function automatic logic reg_hit(input logic [7:0] a,
		input logic [7:0] off);
		reg_hit = (a == off);
	endfunction : reg_hit

	logic        setup_ph;
	logic        wr_now;
	logic        wr_byte0;
	logic        mapped;
	logic [7:0]  wbyte;
	logic [31:0] rd_word;
	logic [1:0]  duty_low_bits;
	logic [3:0]  channel_mode_select;
	logic        pwm_mode;
	logic [9:0]  duty_full;
	logic [9:0]  shadow_full;
	logic [9:0]  time_base;
	logic        duty_match;
	logic        next_pin;
	logic        next_oe;
	logic [0:0]  next_status;
	logic        clear_match;

	assign setup_ph = psel && !penable;
	assign wr_now   = psel && penable && pwrite && pready && !pslverr;
	assign wr_byte0 = wr_now && pstrb[0];
	assign wbyte    = pwdata[7:0];
	assign mapped   = reg_hit(paddr, OFF_PERIOD) ||
		reg_hit(paddr, OFF_COUNT) || reg_hit(paddr, OFF_TB_CTRL) ||
		reg_hit(paddr, OFF_CH_CTRL) || reg_hit(paddr, OFF_DUTY_HIGH) ||
		reg_hit(paddr, OFF_SHADOW) || reg_hit(paddr, OFF_PIN_DIR) ||
		reg_hit(paddr, OFF_IRQ_STAT) || reg_hit(paddr, OFF_IRQ_MASK) ||
		reg_hit(paddr, OFF_ALT_PIN);

	// reserved bits are zero-extended on read
	assign rd_word =
		reg_hit(paddr, OFF_PERIOD)    ? {24'h0, period_compare_value} :
		reg_hit(paddr, OFF_COUNT)     ? {24'h0, tb.count} :
		reg_hit(paddr, OFF_TB_CTRL)   ? {25'h0, timebase_control} :
		reg_hit(paddr, OFF_CH_CTRL)   ? {26'h0, channel_control} :
		reg_hit(paddr, OFF_DUTY_HIGH) ? {24'h0, duty_high_bits} :
		reg_hit(paddr, OFF_SHADOW)    ? {24'h0, duty_shadow} :
		reg_hit(paddr, OFF_PIN_DIR)   ? {24'h0, pin_direction} :
		reg_hit(paddr, OFF_IRQ_STAT)  ? {31'h0, irq_status} :
		reg_hit(paddr, OFF_IRQ_MASK)  ? {31'h0, irq_mask} :
		reg_hit(paddr, OFF_ALT_PIN)   ? {30'h0, alternate_pin_control} :
		32'h0000_0000;

	// ****************************************
	// apb handshake: no wait states
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph && !mapped;
			if (setup_ph) begin
				prdata <= rd_word;
			end
		end
	end

	// ****************************************
	// configuration registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_compare_value <= RST_PERIOD;
			timebase_control     <= RST_TB_CTRL;
			channel_control      <= RST_CH_CTRL;
			pin_direction        <= RST_PIN_DIR;
			alternate_pin_control <= RST_ALT_PIN;
			irq_mask             <= 1'b0;
		end else if (wr_byte0) begin
			if (reg_hit(paddr, OFF_PERIOD)) begin
				period_compare_value <= wbyte;
			end
			if (reg_hit(paddr, OFF_TB_CTRL)) begin
				timebase_control <= wbyte[6:0] & MASK_TB_CTRL[6:0];
			end
			if (reg_hit(paddr, OFF_CH_CTRL)) begin
				channel_control <= wbyte[5:0] & MASK_CH_CTRL[5:0];
			end
			if (reg_hit(paddr, OFF_PIN_DIR)) begin
				pin_direction <= wbyte;
			end
			if (reg_hit(paddr, OFF_ALT_PIN)) begin
				alternate_pin_control <= wbyte[1:0] & MASK_ALT_PIN[1:0];
			end
			if (reg_hit(paddr, OFF_IRQ_MASK)) begin
				irq_mask <= wbyte[IRQ_MATCH];
			end
		end
	end

	// duty byte survives ordinary resets
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			duty_high_bits <= RST_DUTY;
		end else if (wr_byte0 && reg_hit(paddr, OFF_DUTY_HIGH)) begin
			duty_high_bits <= wbyte;
		end
	end

	// ****************************************
	// time base hookup
	// ****************************************
	assign tb.run          = timebase_control[TB_RUN_BIT];
	assign tb.prescale_sel = prescale_t'(timebase_control[TB_PRE_LSB +: 2]);
	assign tb.period       = period_compare_value;
	assign tb.sleep        = sleep;
	assign tb.load         = wr_byte0 && reg_hit(paddr, OFF_COUNT);
	assign tb.load_value   = wbyte;

	// ****************************************
	// duty double buffer and compare
	// ****************************************
	assign duty_low_bits       = channel_control[CH_DUTY_LSB +: 2];
	assign channel_mode_select = channel_control[CH_MODE_LSB +: 4];
	assign pwm_mode    = channel_mode_select[3:2] == MODE_PWM_TOP;
	assign duty_full   = {duty_high_bits, duty_low_bits};
	assign shadow_full = {duty_shadow, duty_shadow_low};
	assign time_base   = {tb.count, tb.fine};
	// a duty beyond the period never matches, pin stays put
	assign duty_match  = pwm_mode && (time_base == shadow_full);

	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			duty_shadow     <= RST_DUTY;
			duty_shadow_low <= 2'h0;
		end else if (tb.wrap) begin
			duty_shadow     <= duty_high_bits;
			duty_shadow_low <= duty_low_bits;
		end
	end

	// ****************************************
	// output pin
	// ****************************************
	assign next_pin =
		!pwm_mode  ? 1'b0 :
		sleep      ? modulated_output_pin :
		tb.wrap    ? (duty_full != 10'h000) :
		duty_match ? 1'b0 :
		modulated_output_pin;
	assign next_oe = sleep ? modulated_output_oe :
		(pwm_mode && !pin_direction[DIR_BIT]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			modulated_output_pin <= 1'b0;
			modulated_output_oe  <= 1'b0;
		end else begin
			modulated_output_pin <= next_pin;
			modulated_output_oe  <= next_oe;
		end
	end

	// ****************************************
	// period match flag and interrupt
	// ****************************************
	assign clear_match = wr_byte0 && reg_hit(paddr, OFF_IRQ_STAT) &&
		wbyte[IRQ_MATCH];
	// a new match wins over a simultaneous clear
	assign next_status = tb.wrap ? 1'b1 :
		clear_match ? 1'b0 : irq_status;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= 1'b0;
			irq        <= 1'b0;
		end else begin
			irq_status <= next_status;
			irq        <= |(next_status & irq_mask);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence wrap_step;
		tb.wrap && pwm_mode && !sleep;
	endsequence

	sequence set_step;
		wrap_step ##0 (duty_full != 10'h000);
	endsequence

	pin_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		set_step |=> modulated_output_pin)
		else $error("pin not set at period boundary");
	zero_duty_a: assert property (@(posedge pclk) disable iff (!presetn)
		wrap_step ##0 (duty_full == 10'h000) |=> !modulated_output_pin)
		else $error("pin set with zero duty");
	shadow_latch_a: assert property (@(posedge pclk) disable iff (!por_n)
		tb.wrap |=> shadow_full == $past(duty_full))
		else $error("shadow duty not latched at boundary");
	shadow_hold_a: assert property (@(posedge pclk) disable iff (!por_n)
		!tb.wrap |=> $stable(shadow_full))
		else $error("shadow duty changed mid period");
	pin_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		duty_match && !tb.wrap && !sleep |=> !modulated_output_pin)
		else $error("pin not cleared on duty match");
	long_duty_a: assert property (@(posedge pclk) disable iff (!presetn)
		pwm_mode && !tb.wrap && !duty_match && !$past(sleep) &&
		(shadow_full > {period_compare_value, 2'h3})
		|=> $stable(modulated_output_pin))
		else $error("pin toggled with duty beyond period");
	sleep_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
		sleep && pwm_mode |=> $stable(modulated_output_pin) &&
		$stable(modulated_output_oe))
		else $error("pin level changed during sleep");
	wake_resume_a: assert property (@(posedge pclk) disable iff (!presetn)
		sleep ##1 (!sleep && !tb.load) |-> tb.count == $past(tb.count))
		else $error("counter reloaded on wake");
	reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup_ph && reg_hit(paddr, OFF_TB_CTRL)
		|=> prdata[31:7] == 25'h0)
		else $error("reserved timer control bits read nonzero");
	irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
		##1 irq == |($past(next_status) & $past(irq_mask)))
		else $error("interrupt does not follow masked status");
	flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		tb.wrap |=> irq_status[IRQ_MATCH] ##1 1'b1)
		else $error("match flag lost on period boundary");
endmodule : pwm_channel

/* design/pwm_timebase.sv */
`timescale 1ns/1ps
module pwm_timebase (
	input  wire logic   pclk,
	input  wire logic   presetn,
	timebase_if.counter tb
);
	import pwm_pkg::*;
	// ****************************************
	// prescaler and period counter
	// ****************************************
	logic [PRE_W-1:0] pre;
	logic [7:0]       count;
	logic             step;
	logic [1:0]       fine;
	// step ratio is a pure count of pclk edges
	assign step = tb.run && !tb.sleep && (
		(tb.prescale_sel == PRE_DIV1) ? (pre[1:0] == 2'h3) :
		(tb.prescale_sel == PRE_DIV4) ? (pre[3:0] == 4'hF) :
		(pre == 6'h3F));
	assign fine = (tb.prescale_sel == PRE_DIV1) ? pre[1:0] :
		(tb.prescale_sel == PRE_DIV4) ? pre[3:2] : pre[5:4];
	assign tb.wrap  = step && (count == tb.period);
	assign tb.count = count;
	assign tb.fine  = fine;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre <= '0;
		end else if (tb.load) begin
			pre <= '0;
		end else if (tb.run && !tb.sleep) begin
			pre <= pre + 6'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= RST_COUNT;
		end else if (tb.load) begin
			count <= tb.load_value;
		end else if (tb.wrap) begin
			count <= 8'h00;
		end else if (step) begin
			count <= count + 8'h01;
		end
	end

	wrap_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
		tb.wrap && !tb.load |=> count == 8'h00)
		else $error("counter not cleared after period match");
	sleep_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
		tb.sleep && !tb.load |=> $stable(count) && $stable(pre))
		else $error("time base moved during sleep");
endmodule : pwm_timebase

/* pkg/pwm_pkg.sv */
package pwm_pkg;
	// ****************************************
	// register byte addresses
	// ****************************************
	localparam logic [7:0] OFF_PERIOD    = 8'h00;
	localparam logic [7:0] OFF_COUNT     = 8'h04;
	localparam logic [7:0] OFF_TB_CTRL   = 8'h08;
	localparam logic [7:0] OFF_CH_CTRL   = 8'h0C;
	localparam logic [7:0] OFF_DUTY_HIGH = 8'h10;
	localparam logic [7:0] OFF_SHADOW    = 8'h14;
	localparam logic [7:0] OFF_PIN_DIR   = 8'h18;
	localparam logic [7:0] OFF_IRQ_STAT  = 8'h1C;
	localparam logic [7:0] OFF_IRQ_MASK  = 8'h20;
	localparam logic [7:0] OFF_ALT_PIN   = 8'h24;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RST_PERIOD    = 8'hFF;
	localparam logic [7:0] RST_COUNT     = 8'h00;
	localparam logic [6:0] RST_TB_CTRL   = 7'h00;
	localparam logic [5:0] RST_CH_CTRL   = 6'h00;
	localparam logic [7:0] RST_DUTY      = 8'h00;
	localparam logic [7:0] RST_PIN_DIR   = 8'hFF;
	localparam logic [1:0] RST_ALT_PIN   = 2'h0;
	// ****************************************
	// implemented field masks and positions
	// ****************************************
	localparam logic [7:0] MASK_TB_CTRL  = 8'h7F;
	localparam logic [7:0] MASK_CH_CTRL  = 8'h3F;
	localparam logic [7:0] MASK_ALT_PIN  = 8'h03;
	localparam int TB_RUN_BIT   = 2;
	localparam int TB_PRE_LSB   = 0;
	localparam int CH_DUTY_LSB  = 4;
	localparam int CH_MODE_LSB  = 0;
	localparam int IRQ_MATCH    = 0;
	localparam logic [1:0] MODE_PWM_TOP = 2'b11;
	// ****************************************
	// prescale encodings and ratios
	// ****************************************
	typedef enum logic [1:0] {
		PRE_DIV1  = 2'b00,
		PRE_DIV4  = 2'b01,
		PRE_DIV16 = 2'b10,
		PRE_DIV16B = 2'b11
	} prescale_t;
	localparam int DIV_1  = 1;
	localparam int DIV_4  = 4;
	localparam int DIV_16 = 16;
	localparam int CYCLES_PER_STEP = 4;
	localparam int PRE_W = 6;
	localparam int CLK_MHZ = 50;
endpackage : pwm_pkg

/* pkg/timebase_if.sv */
`timescale 1ns/1ps
interface timebase_if;
	import pwm_pkg::*;
	logic       run;
	prescale_t  prescale_sel;
	logic [7:0] period;
	logic       sleep;
	logic       load;
	logic [7:0] load_value;
	logic [7:0] count;
	logic [1:0] fine;
	logic       wrap;
	modport counter (input run, prescale_sel, period, sleep, load,
		load_value, output count, fine, wrap);
	modport channel (output run, prescale_sel, period, sleep, load,
		load_value, input count, fine, wrap);
endinterface : timebase_if

/* verification/pin_monitor.sv */
`timescale 1ns/1ps
// *****
// receiver at the output pin
// *****
module pin_monitor (
	input  wire logic pclk,
	input  wire logic pin,
	input  wire logic oe,
	output int        high_len,
	output int        period_len
);
	int   run_len;
	int   up_len;
	logic last;
	logic seen;
	// undriven line shows the inverse of its last level
	assign seen = oe ? pin : ~last;
	initial begin
		last = 1'b0;
		run_len = 0;
		up_len = 0;
		high_len = 0;
		period_len = 0;
	end
	// lengths are latched at each rising edge of the line
	always @(posedge pclk) begin
		last <= seen;
		if (seen && !last) begin
			period_len <= run_len;
			high_len   <= up_len;
			run_len    <= 1;
			up_len     <= 1;
		end else begin
			run_len <= run_len + 1;
			up_len  <= up_len + int'(seen);
		end
	end
endmodule : pin_monitor

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import pwm_pkg::*;
	typedef struct {
		logic       w;
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} row_t;
	// *****
	// signals
	// *****
	logic        pclk;
	logic        presetn;
	logic        por_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic        sleep;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pin;
	logic        oe;
	logic        irq;
	int          high_len;
	int          period_len;
	int          mismatches;
	int          samples_checked;
	int          ratio;
	logic [31:0] rdat;
	logic        rerr;
	logic        held;
	logic [31:0] v;
	row_t        rows [19] = '{
		'{1'b0, OFF_PERIOD, 8'h00, 8'hFF},
		'{1'b0, OFF_COUNT, 8'h00, 8'h00},
		'{1'b0, OFF_TB_CTRL, 8'h00, 8'h00},
		'{1'b0, OFF_CH_CTRL, 8'h00, 8'h00},
		'{1'b0, OFF_PIN_DIR, 8'h00, 8'hFF},
		'{1'b0, OFF_IRQ_STAT, 8'h00, 8'h00},
		'{1'b0, OFF_IRQ_MASK, 8'h00, 8'h00},
		'{1'b0, OFF_ALT_PIN, 8'h00, 8'h00},
		'{1'b0, OFF_DUTY_HIGH, 8'h00, 8'h00},
		'{1'b1, OFF_TB_CTRL, 8'hFF, 8'h7F},
		'{1'b1, OFF_CH_CTRL, 8'hFF, 8'h3F},
		'{1'b1, OFF_ALT_PIN, 8'hFF, 8'h03},
		'{1'b1, OFF_TB_CTRL, 8'h00, 8'h00},
		'{1'b1, OFF_PIN_DIR, 8'hFF, 8'hFF},
		'{1'b1, OFF_PERIOD, 8'h03, 8'h03},
		'{1'b1, OFF_CH_CTRL, 8'h2C, 8'h2C},
		'{1'b1, OFF_DUTY_HIGH, 8'h01, 8'h01},
		'{1'b1, OFF_IRQ_MASK, 8'h01, 8'h01},
		'{1'b0, OFF_SHADOW, 8'h00, 8'h00}
	};
	// *****
	// design and receiver
	// *****
	pwm_channel #(.DIR_BIT(0)) pwm_channel_inst (
		.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .sleep(sleep), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .modulated_output_pin(pin),
		.modulated_output_oe(oe), .irq(irq));
	pin_monitor pin_monitor_inst (.pclk(pclk), .pin(pin), .oe(oe),
		.high_len(high_len), .period_len(period_len));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// *****
	// tasks
	// *****
	task automatic wrap_up();
		$display("mismatches %0d samples_checked %0d", mismatches,
			samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up
	task automatic check(input string n, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", n, e, g);
			mismatches++;
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 20) begin
			mismatches++;
			wrap_up();
		end
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check($sformatf("reg %h", a), e, rdat);
	endtask : rd
	// *****
	// main sequence
	// *****
	initial begin
		{psel, penable, pwrite, sleep} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hF;
		presetn = 1'b0;
		por_n = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		@(posedge pclk);
		foreach (rows[i]) begin
			if (rows[i].w)
				apb(1'b1, rows[i].a, {24'h0, rows[i].d});
			rd(rows[i].a, {24'h0, rows[i].e});
		end
		for (int p = 0; p < 4; p++) begin
			ratio = (p == 0) ? 1 : (p == 1) ? 4 : 16;
			apb(1'b1, OFF_COUNT, 32'h0);
			apb(1'b1, OFF_IRQ_STAT, 32'h1);
			apb(1'b1, OFF_TB_CTRL, 32'(p));
			apb(1'b1, OFF_TB_CTRL, 32'(p + 4));
			// poll the flag itself: rdat still holds the timer control value read during the last write
			for (int n = 0; n <= 200; n++) begin
				if (n == 200) begin
					mismatches++;
					wrap_up();
				end
				apb(1'b0, OFF_IRQ_STAT, 32'h0);
				if (rdat[0] === 1'b1)
					break;
			end
			apb(1'b1, OFF_PIN_DIR, 32'hFE);
			repeat (48 * ratio) @(posedge pclk);
			check("period", 32'(16 * ratio), 32'(period_len));
			// pin falls on the edge after the time base reaches the duty
			check("high", 32'(6 * ratio + 1), 32'(high_len));
			check("irq", 32'h1, {31'h0, irq});
			apb(1'b1, OFF_TB_CTRL, 32'h0);
		end
		rd(OFF_SHADOW, 32'h01);
		apb(1'b1, OFF_IRQ_MASK, 32'h0);
		@(posedge pclk);
		#1;
		check("irq", 32'h0, {31'h0, irq});
		rd(OFF_IRQ_STAT, 32'h1);
		apb(1'b1, OFF_IRQ_STAT, 32'h1);
		rd(OFF_IRQ_STAT, 32'h0);
		apb(1'b1, OFF_TB_CTRL, 32'h4);
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, OFF_DUTY_HIGH, k ? 32'h00 : 32'hFF);
			apb(1'b1, OFF_CH_CTRL, k ? 32'h0C : 32'h3C);
			repeat (40) @(posedge pclk);
			for (int c = 0; c < 16; c++) begin
				@(posedge pclk);
				check("pin", 32'(k == 0), {31'h0, pin});
			end
		end
		apb(1'b1, OFF_PERIOD, 32'hFF);
		apb(1'b1, OFF_COUNT, 32'h0);
		apb(1'b1, OFF_TB_CTRL, 32'h7);
		repeat (300) @(posedge pclk);
		sleep <= 1'b1;
		@(posedge pclk);
		apb(1'b0, OFF_COUNT, 32'h0);
		v = rdat;
		held = pin;
		repeat (100) @(posedge pclk);
		rd(OFF_COUNT, v);
		check("pin", {31'h0, held}, {31'h0, pin});
		sleep <= 1'b0;
		repeat (2) @(posedge pclk);
		apb(1'b0, OFF_COUNT, 32'h0);
		check("resume", 32'h1, 32'(rdat === v || rdat === v + 1));
		apb(1'b0, 8'h30, 32'h0);
		check("slverr", 32'h1, {31'h0, rerr});
		check("rdata", 32'h0, rdat);
		apb(1'b1, OFF_DUTY_HIGH, 32'h5A);
		apb(1'b1, OFF_PIN_DIR, 32'hFE);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		check("oe", 32'h0, {31'h0, oe});
		check("pin", 32'h0, {31'h0, pin});
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFF_PIN_DIR, 32'hFF);
		rd(OFF_CH_CTRL, 32'h00);
		rd(OFF_DUTY_HIGH, 32'h5A);
		por_n <= 1'b0;
		repeat (2) @(posedge pclk);
		por_n <= 1'b1;
		@(posedge pclk);
		rd(OFF_DUTY_HIGH, 32'h00);
		wrap_up();
	end
endmodule : tb_top
